// File: design/misc_ctrl_bank.sv
// misc_ctrl_bank: misc control and high rate sampling registers of the codec,
// with short frame sync checking, notch output delay and clock/mute steering.
// assumes a control port front end that presents decoded register writes,
// and i_ref_clk being the master clock.
//
// Summary of operation
// - the dac 32x oversampling enable bit turns the dac 32x mode on or off.
// - the adc 32x oversampling enable bit turns the adc 32x mode on or off.
// - the force four wire bit selects four wire serial mode whatever the mode pin says.
// - threshold codes 00, 01, 10, 11 select 255, 253, 254, 255 master clock edges.
// - with flush enabled each short frame event resets the processing state, else it is ignored.
// - short frame detection runs while its control bit is 0 and stops while it is 1.
// - with the no-delay bit clear the notch output is used 512 sample periods after enable.
// - with hard mute set the dac limiter output is forced to exactly zero in soft mute.
// - with bypass clear the pll oscillator output is disabled while the pll is unlocked.
// - the force 256x bit makes the dac use 256x whatever the normal select bit says.
`default_nettype none

module misc_ctrl_bank
#(
    parameter int NOTCH_DELAY = misc_ctrl_pkg::NOTCH_DELAY_SAMPLES
)
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst,
    input  wire logic       i_reg_wr,
    input  wire logic [6:0] i_reg_addr,
    input  wire logic [8:0] i_reg_wdata,
    output logic      [8:0] o_reg_rdata,
    input  wire logic       i_mode_pin,
    input  wire logic       i_fs,
    input  wire logic       i_pll_locked,
    input  wire logic       i_notch_en,
    input  wire logic       i_sample_tick,
    input  wire logic       i_soft_mute,
    input  wire logic       i_dac_osr_sel,
    output logic            o_four_wire_mode,
    output logic            o_dac_osr32,
    output logic            o_adc_osr32,
    output logic            o_dac_osr256,
    output logic            o_short_frame,
    output logic            o_dsp_flush,
    output logic            o_notch_out_use,
    output logic            o_limiter_zero,
    output logic            o_pll_out_en
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    localparam logic [9:0] DLY_LOAD = NOTCH_DELAY[9:0];

    if (NOTCH_DELAY < 1 || NOTCH_DELAY > 1023)
    begin : g_bad_delay
        $error("notch delay must fit 1..1023 samples");
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [8:0] high_rate_sampling_ctrl_r;
    logic [8:0] misc_controls_r;

    wire logic wr_high;
    wire logic wr_misc;
    assign wr_high = i_reg_wr && (i_reg_addr == misc_ctrl_pkg::HIGH_RATE_ADDR);
    assign wr_misc = i_reg_wr && (i_reg_addr == misc_ctrl_pkg::MISC_ADDR);

    wire logic [8:0] rdata_nxt;
    assign rdata_nxt = (i_reg_addr == misc_ctrl_pkg::HIGH_RATE_ADDR) ? high_rate_sampling_ctrl_r :
                       (i_reg_addr == misc_ctrl_pkg::MISC_ADDR)      ? misc_controls_r :
                                                                       9'h000;

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            high_rate_sampling_ctrl_r <= misc_ctrl_pkg::HIGH_RATE_RESET;
            misc_controls_r           <= misc_ctrl_pkg::MISC_RESET;
            o_reg_rdata               <= 9'h000;
        end
        else
        begin
            if (wr_high)
            begin
                high_rate_sampling_ctrl_r <= i_reg_wdata;
            end
            if (wr_misc)
            begin
                misc_controls_r <= i_reg_wdata;
            end
            o_reg_rdata <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    wire logic       dac_osr32_en;
    wire logic       adc_osr32_en;
    wire logic       force_four_wire_serial;
    wire logic [1:0] short_frame_threshold_sel;
    wire logic       short_frame_flush_en;
    wire logic       short_frame_detect_off;
    wire logic       notch_output_no_delay;
    wire logic       limiter_hard_mute;
    wire logic       pll_unlocked_bypass;
    wire logic       dac_force_256x_oversample;

    assign dac_osr32_en              = high_rate_sampling_ctrl_r[misc_ctrl_pkg::DAC_OSR32_BIT];
    assign adc_osr32_en              = high_rate_sampling_ctrl_r[misc_ctrl_pkg::ADC_OSR32_BIT];
    assign force_four_wire_serial    = misc_controls_r[misc_ctrl_pkg::FOUR_WIRE_BIT];
    assign short_frame_threshold_sel = misc_controls_r[misc_ctrl_pkg::THR_SEL_MSB:misc_ctrl_pkg::THR_SEL_LSB];
    assign short_frame_flush_en      = misc_controls_r[misc_ctrl_pkg::FLUSH_EN_BIT];
    assign short_frame_detect_off    = misc_controls_r[misc_ctrl_pkg::DETECT_OFF_BIT];
    assign notch_output_no_delay     = misc_controls_r[misc_ctrl_pkg::NOTCH_NO_DLY_BIT];
    assign limiter_hard_mute         = misc_controls_r[misc_ctrl_pkg::HARD_MUTE_BIT];
    assign pll_unlocked_bypass       = misc_controls_r[misc_ctrl_pkg::PLL_BYPASS_BIT];
    assign dac_force_256x_oversample = misc_controls_r[misc_ctrl_pkg::FORCE_256_BIT];

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // pins arrive from outside the clock domain: two flops before use
    logic [1:0] mode_sync_r;
    logic [1:0] fs_sync_r;
    logic [1:0] lock_sync_r;
    logic       fs_prev_r;

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            mode_sync_r <= 2'h0;
            fs_sync_r   <= 2'h0;
            lock_sync_r <= 2'h0;
            fs_prev_r   <= 1'b0;
        end
        else
        begin
            mode_sync_r <= {mode_sync_r[0], i_mode_pin};
            fs_sync_r   <= {fs_sync_r[0], i_fs};
            lock_sync_r <= {lock_sync_r[0], i_pll_locked};
            fs_prev_r   <= fs_sync_r[1];
        end
    end

    wire logic fs_rise;
    assign fs_rise = fs_sync_r[1] && !fs_prev_r;

    // ------------------------------------------------------------
    // short frame detection
    // ------------------------------------------------------------
    wire logic detect_en;
    wire logic short_evt;
    assign detect_en = !short_frame_detect_off;

    short_frame_detect u_short_frame_detect
    (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_enable  (detect_en),
        .i_thr_sel (short_frame_threshold_sel),
        .i_fs_rise (fs_rise),
        .o_short   (short_evt)
    );

    // ------------------------------------------------------------
    // notch output delay
    // ------------------------------------------------------------
    // restarts on each notch enable so a quick off/on still waits fully
    logic [9:0] notch_cnt_r;
    logic       notch_prev_r;

    wire logic       notch_rise;
    wire logic       notch_wait;
    wire logic [9:0] notch_cnt_nxt;
    assign notch_rise    = i_notch_en && !notch_prev_r;
    assign notch_wait    = (notch_cnt_r != 10'h000);
    assign notch_cnt_nxt = notch_rise ? DLY_LOAD :
                           (notch_wait && i_sample_tick) ? notch_cnt_r - 10'h001 : notch_cnt_r;

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            notch_cnt_r  <= 10'h000;
            notch_prev_r <= 1'b0;
        end
        else
        begin
            notch_cnt_r  <= notch_cnt_nxt;
            notch_prev_r <= i_notch_en;
        end
    end

    // ------------------------------------------------------------
    // output steering
    // ------------------------------------------------------------
    wire logic notch_use_nxt;
    assign notch_use_nxt = i_notch_en && !notch_rise && (notch_output_no_delay || !notch_wait);

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            o_four_wire_mode <= 1'b0;
            o_dac_osr32      <= 1'b0;
            o_adc_osr32      <= 1'b0;
            o_dac_osr256     <= 1'b0;
            o_short_frame    <= 1'b0;
            o_dsp_flush      <= 1'b0;
            o_notch_out_use  <= 1'b0;
            o_limiter_zero   <= 1'b0;
            o_pll_out_en     <= 1'b0;
        end
        else
        begin
            o_dac_osr32      <= dac_osr32_en;
            o_adc_osr32      <= adc_osr32_en;
            o_four_wire_mode <= force_four_wire_serial || mode_sync_r[1];
            o_short_frame    <= short_evt;
            o_dsp_flush      <= short_evt && short_frame_flush_en;
            o_notch_out_use  <= notch_use_nxt;
            o_limiter_zero   <= limiter_hard_mute && i_soft_mute;
            o_pll_out_en     <= pll_unlocked_bypass || lock_sync_r[1];
            o_dac_osr256     <= dac_force_256x_oversample || i_dac_osr_sel;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_dac_osr32;
        @(posedge i_ref_clk) disable iff (i_rst)
        wr_high ##1 1'b1 |=> (o_dac_osr32 == $past(i_reg_wdata[misc_ctrl_pkg::DAC_OSR32_BIT], 2));
    endproperty
    a_dac_osr32: assert property (p_dac_osr32) else $error("dac 32x does not follow its bit");

    property p_adc_osr32;
        @(posedge i_ref_clk) disable iff (i_rst)
        $rose(adc_osr32_en) |=> o_adc_osr32;
    endproperty
    a_adc_osr32: assert property (p_adc_osr32) else $error("adc 32x not enabled after bit set");

    property p_four_wire;
        @(posedge i_ref_clk) disable iff (i_rst)
        force_four_wire_serial ##1 force_four_wire_serial |-> o_four_wire_mode;
    endproperty
    a_four_wire: assert property (p_four_wire) else $error("four wire mode not forced");

    property p_threshold;
        @(posedge i_ref_clk) disable iff (i_rst)
        (short_frame_threshold_sel == 2'h1) |-> (u_short_frame_detect.thr == 8'hFD);
    endproperty
    a_threshold: assert property (p_threshold) else $error("threshold code 01 is not 253");

    property p_flush;
        @(posedge i_ref_clk) disable iff (i_rst)
        o_dsp_flush |-> o_short_frame && $past(short_frame_flush_en);
    endproperty
    a_flush: assert property (p_flush) else $error("flush without enabled short frame");

    property p_detect_off;
        @(posedge i_ref_clk) disable iff (i_rst)
        short_frame_detect_off ##1 short_frame_detect_off |-> ##1 !o_short_frame;
    endproperty
    a_detect_off: assert property (p_detect_off) else $error("short frame flagged while off");

    property p_notch_delay;
        @(posedge i_ref_clk) disable iff (i_rst)
        notch_rise && !notch_output_no_delay |=> !o_notch_out_use && (notch_cnt_r == DLY_LOAD);
    endproperty
    a_notch_delay: assert property (p_notch_delay) else $error("notch output used before delay");

    property p_hard_mute;
        @(posedge i_ref_clk) disable iff (i_rst)
        o_limiter_zero |-> $past(i_soft_mute) && $past(limiter_hard_mute);
    endproperty
    a_hard_mute: assert property (p_hard_mute) else $error("limiter zero without soft mute");

    property p_pll_gate;
        @(posedge i_ref_clk) disable iff (i_rst)
        !pll_unlocked_bypass && !lock_sync_r[1] |=> !o_pll_out_en;
    endproperty
    a_pll_gate: assert property (p_pll_gate) else $error("pll output on while unlocked");

    property p_force_256;
        @(posedge i_ref_clk) disable iff (i_rst)
        dac_force_256x_oversample |=> o_dac_osr256;
    endproperty
    a_force_256: assert property (p_force_256) else $error("dac 256x not forced");

    property p_short_count;
        @(posedge i_ref_clk) disable iff (i_rst)
        short_evt |-> $past(u_short_frame_detect.cnt_r) < $past(u_short_frame_detect.thr);
    endproperty
    a_short_count: assert property (p_short_count) else $error("short frame not below threshold");

endmodule

`default_nettype wire

// File: design/misc_ctrl_pkg.sv
// misc_ctrl_pkg: offsets, field layout, reset values and counts shared by
// the misc control register bank and its short frame detector.
// assumes a 7-bit register address and 9-bit register data on the control port.
`default_nettype none

package misc_ctrl_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int          REG_AW                 = 7;
    localparam int          REG_DW                 = 9;
    localparam logic [6:0]  HIGH_RATE_ADDR         = 7'h48;
    localparam logic [6:0]  MISC_ADDR              = 7'h49;
    localparam logic [8:0]  HIGH_RATE_RESET        = 9'h008;
    localparam logic [8:0]  MISC_RESET             = 9'h000;

    // ------------------------------------------------------------
    // high rate sampling fields
    // ------------------------------------------------------------
    localparam int          DAC_OSR32_BIT          = 1;
    localparam int          ADC_OSR32_BIT          = 0;

    // ------------------------------------------------------------
    // misc control fields
    // ------------------------------------------------------------
    localparam int          FOUR_WIRE_BIT          = 8;
    localparam int          THR_SEL_MSB            = 7;
    localparam int          THR_SEL_LSB            = 6;
    localparam int          FLUSH_EN_BIT           = 5;
    localparam int          DETECT_OFF_BIT         = 4;
    localparam int          NOTCH_NO_DLY_BIT       = 3;
    localparam int          HARD_MUTE_BIT          = 2;
    localparam int          PLL_BYPASS_BIT         = 1;
    localparam int          FORCE_256_BIT          = 0;

    // ------------------------------------------------------------
    // short frame thresholds, in master clock edges
    // ------------------------------------------------------------
    localparam int          FRAME_CNT_W            = 8;
    localparam logic [7:0]  THR_CODE0              = 8'hFF;
    localparam logic [7:0]  THR_CODE1              = 8'hFD;
    localparam logic [7:0]  THR_CODE2              = 8'hFE;
    localparam logic [7:0]  THR_CODE3              = 8'hFF;

    // ------------------------------------------------------------
    // notch output delay, in sample periods
    // ------------------------------------------------------------
    localparam int          NOTCH_DELAY_SAMPLES    = 512;

endpackage

`default_nettype wire

// File: design/short_frame_detect.sv
// short_frame_detect: counts master clock edges between frame sync rises
// and flags frames shorter than the selected threshold.
// assumes i_fs_rise is a one-cycle pulse already synchronised to i_ref_clk.
`default_nettype none

module short_frame_detect
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst,
    input  wire logic       i_enable,
    input  wire logic [1:0] i_thr_sel,
    input  wire logic       i_fs_rise,
    output logic            o_short
);

    // ------------------------------------------------------------
    // threshold decode
    // ------------------------------------------------------------
    wire logic [7:0] thr;
    assign thr = (i_thr_sel == 2'h0) ? misc_ctrl_pkg::THR_CODE0 :
                 (i_thr_sel == 2'h1) ? misc_ctrl_pkg::THR_CODE1 :
                 (i_thr_sel == 2'h2) ? misc_ctrl_pkg::THR_CODE2 :
                                       misc_ctrl_pkg::THR_CODE3;

    logic [7:0] cnt_r;
    logic       armed_r;

    wire logic       sat;
    wire logic [7:0] cnt_nxt;
    wire logic       short_hit;
    assign sat       = (cnt_r == 8'hFF);
    assign cnt_nxt   = i_fs_rise ? 8'h01 : (sat ? cnt_r : cnt_r + 8'h01);
    // first rise after enable only arms: no previous frame to measure
    assign short_hit = i_enable && armed_r && i_fs_rise && (cnt_r < thr);

    // ------------------------------------------------------------
    // frame counter
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst || !i_enable)
        begin
            cnt_r   <= 8'h00;
            armed_r <= 1'b0;
            o_short <= 1'b0;
        end
        else
        begin
            cnt_r   <= cnt_nxt;
            armed_r <= armed_r | i_fs_rise;
            o_short <= short_hit;
        end
    end

endmodule

`default_nettype wire

// File: testbench/misc_control_frame_sync_check_tb.sv
// misc_control_frame_sync_check_tb: self-checking bench for misc_ctrl_bank.
// assumes the bench drives every port itself; expectations are queued by the
// driver and compared by a separate monitor on the falling clock edge.
`default_nettype none

module misc_control_frame_sync_check_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    typedef struct {int due; int sel; logic [8:0] val;} note_type;

    logic       i_ref_clk = 1'b0;
    logic       i_rst = 1'b1;
    logic       i_reg_wr = 1'b0;
    logic [6:0] i_reg_addr = 7'h00;
    logic [8:0] i_reg_wdata = 9'h000;
    logic       i_mode_pin = 1'b0;
    logic       i_fs = 1'b0;
    logic       i_pll_locked = 1'b0;
    logic       i_notch_en = 1'b0;
    logic       i_sample_tick = 1'b0;
    logic       i_soft_mute = 1'b0;
    logic       i_dac_osr_sel = 1'b0;
    logic [8:0] o_reg_rdata;
    logic       o_four_wire_mode;
    logic       o_dac_osr32;
    logic       o_adc_osr32;
    logic       o_dac_osr256;
    logic       o_short_frame;
    logic       o_dsp_flush;
    logic       o_notch_out_use;
    logic       o_limiter_zero;
    logic       o_pll_out_en;
    note_type   exp_q[$];
    note_type   n;
    int         cyc = 0;
    int         err_count = 0;
    int         tests_run = 0;
    int         thr;
    logic [8:0] sf_cnt = 9'h000;
    logic [8:0] fl_cnt = 9'h000;
    logic [8:0] exp_sf = 9'h000;
    logic [8:0] exp_fl = 9'h000;
    logic [8:0] dh;
    logic [8:0] dm;
    logic [3:0] r;
    logic [6:0] flags;

    always #5 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) cyc <= cyc + 1;

    misc_ctrl_bank #(.NOTCH_DELAY(4)) u_dut
    (
        .i_ref_clk        (i_ref_clk),
        .i_rst            (i_rst),
        .i_reg_wr         (i_reg_wr),
        .i_reg_addr       (i_reg_addr),
        .i_reg_wdata      (i_reg_wdata),
        .o_reg_rdata      (o_reg_rdata),
        .i_mode_pin       (i_mode_pin),
        .i_fs             (i_fs),
        .i_pll_locked     (i_pll_locked),
        .i_notch_en       (i_notch_en),
        .i_sample_tick    (i_sample_tick),
        .i_soft_mute      (i_soft_mute),
        .i_dac_osr_sel    (i_dac_osr_sel),
        .o_four_wire_mode (o_four_wire_mode),
        .o_dac_osr32      (o_dac_osr32),
        .o_adc_osr32      (o_adc_osr32),
        .o_dac_osr256     (o_dac_osr256),
        .o_short_frame    (o_short_frame),
        .o_dsp_flush      (o_dsp_flush),
        .o_notch_out_use  (o_notch_out_use),
        .o_limiter_zero   (o_limiter_zero),
        .o_pll_out_en     (o_pll_out_en)
    );

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic check(input int sel, input logic [8:0] seen, input logic [8:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error at %0t: sel %0d saw %h expected %h", $time, sel, seen, exp);
        end
    endtask

    task automatic test_done();
        if (exp_q.size() > 0)
            err_count++;
        $display("checks run %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // sel map: 0 rdata, 1 short count, 2 flush count, 3.. single-bit outputs
    assign flags = {o_pll_out_en, o_limiter_zero, o_notch_out_use, o_dac_osr256,
                    o_adc_osr32, o_dac_osr32, o_four_wire_mode};

    // compare on the falling edge so registered outputs have settled
    always @(negedge i_ref_clk)
    begin
        if (o_short_frame === 1'b1)
            sf_cnt = sf_cnt + 9'h001;
        if (o_dsp_flush === 1'b1)
            fl_cnt = fl_cnt + 9'h001;
        while (exp_q.size() > 0 && exp_q[0].due <= cyc)
        begin
            n = exp_q.pop_front();
            check(n.sel, (n.sel == 0) ? o_reg_rdata : (n.sel == 1) ? sf_cnt : (n.sel == 2) ? fl_cnt :
                  {8'h00, flags[n.sel-3]}, n.val);
        end
    end

    initial
    begin
        #200us;
        err_count++;
        test_done();
    end

    // ------------------------------------------------------------
    // driver tasks
    // ------------------------------------------------------------
    task automatic step(input int k);
        repeat (k) @(posedge i_ref_clk);
        #1;
    endtask

    // one cycle per note keeps inputs still until the monitor has compared
    task automatic chk(input int sel, input logic [8:0] v);
        exp_q.push_back('{cyc, sel, v});
        step(1);
    endtask

    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        i_reg_wr = 1'b1;
        i_reg_addr = a;
        i_reg_wdata = d;
        step(1);
        i_reg_wr = 1'b0;
        step(1);
    endtask

    task automatic rd(input logic [6:0] a, input logic [8:0] exp);
        i_reg_addr = a;
        step(2);
        chk(0, exp);
    endtask

    // rise now, next rise k cycles later
    task automatic frame(input int k);
        i_fs = 1'b1;
        step(4);
        i_fs = 1'b0;
        step(k - 4);
    endtask

    task automatic tick();
        i_sample_tick = 1'b1;
        step(1);
        i_sample_tick = 1'b0;
        step(1);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h0000_f21d));
        step(6);
        i_rst = 1'b0;
        rd(misc_ctrl_pkg::HIGH_RATE_ADDR, misc_ctrl_pkg::HIGH_RATE_RESET);
        rd(misc_ctrl_pkg::MISC_ADDR, misc_ctrl_pkg::MISC_RESET);
        rd(7'h4a, 9'h000);
        chk(4, 9'h000);
        chk(5, 9'h000);
        for (int k = 0; k < 6; k++)
        begin
            dh = 9'($urandom);
            dm = 9'($urandom);
            r = 4'($urandom);
            {i_mode_pin, i_dac_osr_sel, i_soft_mute, i_pll_locked} = r;
            wr(misc_ctrl_pkg::HIGH_RATE_ADDR, dh);
            wr(misc_ctrl_pkg::MISC_ADDR, dm);
            wr(7'h4a, ~dm);
            step(4);
            chk(4, {8'h00, dh[1]});
            chk(5, {8'h00, dh[0]});
            chk(3, {8'h00, dm[8] | r[3]});
            chk(6, {8'h00, dm[0] | r[2]});
            chk(8, {8'h00, dm[2] & r[1]});
            chk(9, {8'h00, dm[1] | r[0]});
            rd(misc_ctrl_pkg::HIGH_RATE_ADDR, dh);
            rd(misc_ctrl_pkg::MISC_ADDR, dm);
            rd(7'h4a, 9'h000);
        end
        // each code: one frame just under and one just over its threshold
        for (int c = 0; c < 4; c++)
        begin
            thr = (c == 1) ? 253 : (c == 2) ? 254 : 255;
            wr(misc_ctrl_pkg::MISC_ADDR, {1'b0, 2'(c), 1'(c), 5'h00});
            frame(300);
            frame(thr - 1);
            frame(thr + 1);
            frame(300);
            exp_sf = exp_sf + 9'h001;
            exp_fl = exp_fl + 9'(c % 2);
            chk(1, exp_sf);
            chk(2, exp_fl);
        end
        wr(misc_ctrl_pkg::MISC_ADDR, 9'h030);
        frame(300);
        frame(10);
        frame(10);
        frame(300);
        chk(1, exp_sf);
        chk(2, exp_fl);
        wr(misc_ctrl_pkg::MISC_ADDR, 9'h020);
        frame(300);
        frame(10);
        frame(300);
        exp_sf = exp_sf + 9'h001;
        exp_fl = exp_fl + 9'h001;
        chk(1, exp_sf);
        chk(2, exp_fl);
        // notch delay shortened to 4 sample periods
        wr(misc_ctrl_pkg::MISC_ADDR, 9'h000);
        i_notch_en = 1'b1;
        step(3);
        repeat (3) tick();
        chk(7, 9'h000);
        tick();
        step(3);
        chk(7, 9'h001);
        i_notch_en = 1'b0;
        step(3);
        chk(7, 9'h000);
        wr(misc_ctrl_pkg::MISC_ADDR, 9'h008);
        i_notch_en = 1'b1;
        step(3);
        chk(7, 9'h001);
        i_notch_en = 1'b0;
        step(3);
        test_done();
    end
endmodule

`default_nettype wire
